// [cpmc_clock_power.v]
// clock and power mode control: registers, oscillator select, sleep entry
// Notes on behaviour
// - core clock divided by 2**code, 16M..125k
// - osc field picks both, rc or crystal
// - default runs rc, then crystal once running
// - osc field applied only after retention/deep sleep
// - bypass takes core clock from crystal pin
// - crystal-ready irq gated by enable bit
// - low-freq register shows phase and ready
// - status bit shows crystal is clock source
// - three-bit low-freq source select
// - synthesized low clock off with crystal stopped
// - hold core start until low clock runs
// - power-down write of 1-4 or 7 enters a mode
// - power-down read returns previous mode
// - wakeup cause flags pin, tick, comparator
// - cause flags clear on read or entry
// - register retention timers follow low source
// - register retention/standby wake resumes, no reset
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "cpmc_defs.vh"
module cpmc_clock_power (
  input  wire       sys_clk,          // block clock, 200 MHz
  input  wire       srst,             // synchronous reset, active high
  input  wire [7:0] reg_addr,         // register address
  input  wire [7:0] reg_wdata,        // write data
  input  wire       reg_wr,           // write strobe
  input  wire       reg_rd,           // read strobe
  output reg  [7:0] reg_rdata_q,      // read data, cycle after strobe
  input  wire       crystal_16m_ok,   // crystal oscillator running
  input  wire       rc_16m_ok,        // rc oscillator running
  input  wire       low_freq_clock,   // selected 32 kHz clock level
  input  wire       low_freq_ok,      // selected 32 kHz source running
  input  wire       wake_pin,         // pin wakeup event
  input  wire       wake_tick,        // periodic tick wakeup event
  input  wire       wake_comp,        // comparator wakeup event
  input  wire       wake_other,       // any other wakeup source
  output reg        crystal_16m_en_q, // start crystal oscillator
  output reg        rc_16m_en_q,      // start rc oscillator
  output reg        core_src_xtal_q,  // core clock from crystal
  output reg        core_bypass_q,    // core clock from crystal_input_pin
  output reg        core_clk_en_q,    // core clock enable (divided)
  output reg        core_run_q,       // core allowed to execute
  output reg  [2:0] low_freq_sel_q,   // low-freq source to clock tree
  output reg        synth_lf_en_q,    // synthesized 32 kHz running
  output reg        timers_on_q,      // timers powered in sleep
  output reg  [2:0] sleep_mode_q,     // current low-power mode, 0 active
  output reg        system_reset_q,   // wake needs a full restart
  output reg        crystal_ready_irq_q // crystal active pulse
);
  // state codes
  localparam ST_RUN   = 2'h0;  // active
  localparam ST_SLEEP = 2'h1;  // in a low-power mode
  localparam ST_WAIT  = 2'h2;  // waiting for clocks after wake

  reg [7:0] clk_reg_q;     // mcu_clock_setup
  reg [1:0] osc_act_q;     // oscillator-start value in force
  reg [2:0] lf_src_q;      // low_freq_clock_setup source field
  reg [2:0] prev_mode_q;   // previous power-down mode
  reg [2:0] cause_q;       // pin, tick, comparator flags
  reg [2:0] pend_cmd_q;    // command captured from the write
  reg [1:0] state_q;       // control state
  reg       xtal_seen_q;   // crystal was running last cycle
  wire      div_tick;      // divided enable

  // decide if a low-freq source code names a real source
  function lf_active;
    input [2:0] s;
    begin
      lf_active = (s <= `CPMC_LF_PIN_DIG);
    end
  endfunction

  // codes accepted as power-down commands
  function cmd_valid;
    input [2:0] c;
    begin
      cmd_valid = (c != 3'h0) && (c != 3'h5) && (c != 3'h6);
    end
  endfunction

  wire wr_clk = reg_wr && (reg_addr == `CPMC_ADDR_CLK);
  wire wr_pwr = reg_wr && (reg_addr == `CPMC_ADDR_PWR);
  wire wr_lfc = reg_wr && (reg_addr == `CPMC_ADDR_LFC);
  wire rd_pwr = reg_rd && (reg_addr == `CPMC_ADDR_PWR);
  wire any_wake = wake_pin | wake_tick | wake_comp | wake_other;
  wire [2:0] ev = {wake_pin, wake_tick, wake_comp};
  wire [1:0] osc_new = clk_reg_q[`CPMC_CLK_OSC_HI:`CPMC_CLK_OSC_LO];
  wire osc_apply = (pend_cmd_q == `CPMC_MODE_DEEP) ||
                   (pend_cmd_q == `CPMC_MODE_MEM_OFF) ||
                   (pend_cmd_q == `CPMC_MODE_MEM_ON) ||
                   (pend_cmd_q == `CPMC_MODE_REG);
  // crystal stopped in deep sleep and memory retention
  wire xtal_stop = (sleep_mode_q == `CPMC_MODE_DEEP) ||
                   (sleep_mode_q == `CPMC_MODE_MEM_OFF) ||
                   (sleep_mode_q == `CPMC_MODE_MEM_ON);
  // clocks needed before core may run
  wire lf_hold = lf_active(lf_src_q) && !low_freq_ok;
  wire hf_ok = core_src_xtal_q ? crystal_16m_ok : rc_16m_ok;

  // divider for the core clock enable
  cpmc_clk_div u_div (
    .sys_clk (sys_clk),
    .srst    (srst),
    .div_sel (clk_reg_q[2:0]),
    .tick_q  (div_tick)
  );

  // register writes
  always @(posedge sys_clk) begin
    if (srst) begin
      clk_reg_q <= `CPMC_CLK_RESET;
      lf_src_q  <= `CPMC_LFC_SRC_RESET;
    end else begin
      if (wr_clk) begin
        clk_reg_q <= reg_wdata;  // 11 in osc field stored, treated as 00
      end
      if (wr_lfc) begin
        lf_src_q <= reg_wdata[2:0];
      end
    end
  end

  // power state machine; command acted on the cycle after the write
  always @(posedge sys_clk) begin
    if (srst) begin
      state_q        <= ST_WAIT;  // start waits for clocks
      pend_cmd_q     <= 3'h0;
      sleep_mode_q   <= `CPMC_MODE_OFF;
      prev_mode_q    <= `CPMC_MODE_OFF;
      osc_act_q      <= `CPMC_OSC_BOTH;
      system_reset_q <= 1'b0;
    end else begin
      pend_cmd_q     <= wr_pwr ? reg_wdata[2:0] : 3'h0;
      system_reset_q <= 1'b0;
      case (state_q)
        ST_RUN: begin
          if (cmd_valid(pend_cmd_q)) begin
            state_q      <= ST_SLEEP;
            sleep_mode_q <= pend_cmd_q;
            prev_mode_q  <= pend_cmd_q;
            if (osc_apply) begin
              osc_act_q <= osc_new;
            end
          end
        end
        ST_SLEEP: begin
          if (any_wake) begin
            state_q <= ST_WAIT;
            // deep sleep and memory retention restart the core
            system_reset_q <= !((sleep_mode_q == `CPMC_MODE_REG) ||
                                (sleep_mode_q == `CPMC_MODE_STBY));
          end
        end
        ST_WAIT: begin
          sleep_mode_q <= `CPMC_MODE_OFF;
          if (!lf_hold && hf_ok) begin
            state_q <= ST_RUN;
          end
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // wakeup cause flags: set wins over read clear
  always @(posedge sys_clk) begin
    if (srst) begin
      cause_q <= 3'h0;
    end else if (state_q == ST_RUN && cmd_valid(pend_cmd_q)) begin
      cause_q <= 3'h0;
    end else if (rd_pwr) begin
      cause_q <= ev;
    end else if (state_q == ST_SLEEP) begin
      cause_q <= cause_q | ev;
    end
  end

  // oscillator enables, core source and clock outputs
  always @(posedge sys_clk) begin
    if (srst) begin
      crystal_16m_en_q    <= 1'b1;
      rc_16m_en_q         <= 1'b1;
      core_src_xtal_q     <= 1'b0;
      core_bypass_q       <= 1'b0;
      core_clk_en_q       <= 1'b0;
      core_run_q          <= 1'b0;
      low_freq_sel_q      <= `CPMC_LFC_SRC_RESET;
      synth_lf_en_q       <= 1'b0;
      timers_on_q         <= 1'b0;
      xtal_seen_q         <= 1'b0;
      crystal_ready_irq_q <= 1'b0;
    end else begin
      // osc field select; rc kept on in deep sleep is software's job
      crystal_16m_en_q <= (osc_act_q != `CPMC_OSC_RC) && !xtal_stop &&
                          !(sleep_mode_q == `CPMC_MODE_REG &&
                            !clk_reg_q[`CPMC_CLK_KEEPX_BIT]);
      rc_16m_en_q      <= (osc_act_q != `CPMC_OSC_XTAL);
      // rc first, crystal once it runs; never flag a stopped crystal
      core_src_xtal_q  <= (osc_act_q != `CPMC_OSC_RC) &&
                          crystal_16m_ok;
      core_bypass_q    <= clk_reg_q[`CPMC_CLK_BYPASS_BIT];
      core_clk_en_q    <= div_tick && (state_q == ST_RUN);
      core_run_q       <= (state_q == ST_RUN);
      low_freq_sel_q   <= lf_src_q;
      synth_lf_en_q    <= (lf_src_q == `CPMC_LF_SYNTH) &&
                          crystal_16m_ok && !xtal_stop;
      // memory retention follows its code, register retention the source
      timers_on_q      <= (sleep_mode_q == `CPMC_MODE_MEM_ON) ||
                          ((sleep_mode_q == `CPMC_MODE_REG) &&
                           lf_active(lf_src_q));
      xtal_seen_q      <= crystal_16m_ok;
      crystal_ready_irq_q <= crystal_16m_ok && !xtal_seen_q &&
                             clk_reg_q[`CPMC_CLK_XIRQ_BIT];
    end
  end

  // read mux; reserved bits read as zero
  always @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `CPMC_ADDR_CLK: reg_rdata_q <= clk_reg_q;
        `CPMC_ADDR_PWR: reg_rdata_q <= {cause_q, 2'b00,
                                        prev_mode_q};
        `CPMC_ADDR_LFC: reg_rdata_q <= {low_freq_clock, low_freq_ok,
                                        2'b00, core_src_xtal_q,
                                        lf_src_q};
        default:        reg_rdata_q <= 8'h00;
      endcase
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end
endmodule // cpmc_clock_power
`default_nettype wire

// [cpmc_defs.vh]
// register offsets, field positions, reset values and codes for clock control
`ifndef CPMC_DEFS_VH
`define CPMC_DEFS_VH
`define CPMC_ADDR_CLK        8'ha3
`define CPMC_ADDR_PWR        8'ha4
`define CPMC_ADDR_LFC        8'had
`define CPMC_CLK_RESET       8'h00
`define CPMC_PWR_RESET       8'h00
`define CPMC_LFC_RESET       8'h02
`define CPMC_LFC_SRC_RESET   3'h2
`define CPMC_CLK_KEEPX_BIT   7
`define CPMC_CLK_BYPASS_BIT  6
`define CPMC_CLK_OSC_HI      5
`define CPMC_CLK_OSC_LO      4
`define CPMC_CLK_XIRQ_BIT    3
`define CPMC_LFC_PHASE_BIT   7
`define CPMC_LFC_READY_BIT   6
`define CPMC_LFC_XSRC_BIT    3
`define CPMC_PWR_PIN_BIT     7
`define CPMC_PWR_TICK_BIT    6
`define CPMC_PWR_COMP_BIT    5
`define CPMC_OSC_BOTH        2'b00
`define CPMC_OSC_RC          2'b01
`define CPMC_OSC_XTAL        2'b10
`define CPMC_MODE_OFF        3'h0
`define CPMC_MODE_DEEP       3'h1
`define CPMC_MODE_MEM_OFF    3'h2
`define CPMC_MODE_MEM_ON     3'h3
`define CPMC_MODE_REG        3'h4
`define CPMC_MODE_STBY       3'h7
`define CPMC_LF_XTAL32       3'h0
`define CPMC_LF_RC32         3'h1
`define CPMC_LF_SYNTH        3'h2
`define CPMC_LF_PIN_LOW      3'h3
`define CPMC_LF_PIN_DIG      3'h4
`define CPMC_LF_NONE         3'h7
`define CPMC_DIV_W           7
`endif

// [cpmc_clk_div.v]
// core clock enable divider: pulse every 2**sel cycles of the block clock
`timescale 1ns/1ps
`default_nettype none
`include "cpmc_defs.vh"
module cpmc_clk_div (
  input  wire       sys_clk,   // block clock
  input  wire       srst,      // synchronous reset
  input  wire [2:0] div_sel,   // divider code, 000 = undivided
  output reg        tick_q     // one-cycle enable at the divided rate
);
  reg [`CPMC_DIV_W-1:0] cnt_q;  // free running prescaler
  reg [`CPMC_DIV_W-1:0] mask;   // low bits that must be all ones

  // build the mask from the code: 000 -> 0, 111 -> 7f
  always @* begin
    mask = (7'h7f >> (3'h7 - div_sel));
    if (div_sel == 3'h0) begin
      mask = 7'h00;
    end
  end

  // count and fire when masked bits roll over
  always @(posedge sys_clk) begin
    if (srst) begin
      cnt_q  <= 7'h00;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_q + 7'h01;
      tick_q <= ((cnt_q & mask) == mask);
    end
  end
endmodule // cpmc_clk_div
`default_nettype wire

// [cpmc_osc_model.sv]
// oscillator and 32 kHz source model beside the clock control block
`timescale 1ns/1ps
`default_nettype none
module cpmc_osc_model #(
  parameter int START = 6 // cycles from enable to a running oscillator
) (
  input  wire logic sys_clk,          // block clock
  input  wire logic crystal_16m_en_q, // crystal start request
  input  wire logic rc_16m_en_q,      // rc start request
  input  wire logic lf_stop,          // stall the 32 kHz source
  output var  logic crystal_16m_ok,   // crystal running
  output var  logic rc_16m_ok,        // rc running
  output var  logic low_freq_clock,   // 32 kHz level
  output var  logic low_freq_ok       // 32 kHz source running
);
  int xc = 0; // crystal start counter
  int rc = 0; // rc start counter
  initial {crystal_16m_ok, rc_16m_ok, low_freq_clock, low_freq_ok} = 4'h0;
  // run a fixed time after enable, stop at once when the enable drops
  always @(posedge sys_clk) begin
    xc <= crystal_16m_en_q ? (xc < START ? xc + 1 : xc) : 0;
    rc <= rc_16m_en_q ? (rc < START ? rc + 1 : rc) : 0;
    crystal_16m_ok <= crystal_16m_en_q && xc == START;
    rc_16m_ok <= rc_16m_en_q && rc == START;
    // the low clock stands still while stalled
    if (!lf_stop) low_freq_clock <= ~low_freq_clock;
    low_freq_ok <= !lf_stop;
  end
endmodule // cpmc_osc_model
`default_nettype wire

// [cpmc_clock_power_asserts.sv]
// port checker for the clock and power control block
`timescale 1ns/1ps
`default_nettype none
module cpmc_clock_power_asserts (
  input wire logic       sys_clk,             // block clock
  input wire logic       srst,                // synchronous reset
  input wire logic       reg_rd,              // read strobe
  input wire logic [7:0] reg_rdata_q,         // read data
  input wire logic       crystal_16m_ok,      // crystal running
  input wire logic       core_src_xtal_q,     // core on crystal
  input wire logic       core_run_q,          // core may execute
  input wire logic [2:0] low_freq_sel_q,      // low source select
  input wire logic       synth_lf_en_q,       // synthesized low clock
  input wire logic [2:0] sleep_mode_q,        // current mode
  input wire logic       system_reset_q,      // restart pulse
  input wire logic       crystal_ready_irq_q  // crystal ready pulse
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata_q == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside its slot");
  property p_irq_src; crystal_ready_irq_q |-> $past(crystal_16m_ok); endproperty
  a_irq_src: assert property (p_irq_src)
    else $error("crystal ready pulse without crystal");
  property p_irq_one; crystal_ready_irq_q |=> !crystal_ready_irq_q; endproperty
  a_irq_one: assert property (p_irq_one)
    else $error("crystal ready pulse too long");
  property p_synth;
    synth_lf_en_q |-> low_freq_sel_q == 3'h2 && $past(crystal_16m_ok);
  endproperty
  a_synth: assert property (p_synth)
    else $error("synthesized low clock without crystal");
  property p_halt; $rose(sleep_mode_q != 3'h0) |=> !core_run_q; endproperty
  a_halt: assert property (p_halt)
    else $error("core still runs in sleep");
  property p_rst_deep;
    system_reset_q |-> $past(sleep_mode_q) inside {3'h1, 3'h2, 3'h3};
  endproperty
  a_rst_deep: assert property (p_rst_deep)
    else $error("restart pulse outside deep modes");
  property p_rst_one; system_reset_q |=> !system_reset_q; endproperty
  a_rst_one: assert property (p_rst_one)
    else $error("restart pulse too long");
  property p_src; core_src_xtal_q |-> $past(crystal_16m_ok); endproperty
  a_src: assert property (p_src)
    else $error("core on stopped crystal");
  c_irq: cover property (crystal_ready_irq_q);
  c_rst: cover property (system_reset_q);
  c_reg: cover property (sleep_mode_q == 3'h4);
endmodule // cpmc_clock_power_asserts
bind cpmc_clock_power cpmc_clock_power_asserts u_chk (.sys_clk, .srst,
  .reg_rd, .reg_rdata_q, .crystal_16m_ok, .core_src_xtal_q, .core_run_q,
  .low_freq_sel_q, .synth_lf_en_q, .sleep_mode_q, .system_reset_q,
  .crystal_ready_irq_q);
`default_nettype wire

// [clock_and_power_mode_control_tb.sv]
// self-checking bench for the clock and power control block
`timescale 1ns/1ps
`default_nettype none
`include "cpmc_defs.vh"
module clock_and_power_mode_control_tb;
  localparam logic [7:0] ac = `CPMC_ADDR_CLK; // clock setup
  localparam logic [7:0] ap = `CPMC_ADDR_PWR; // power-down command
  localparam logic [7:0] al = `CPMC_ADDR_LFC; // low clock setup
  logic sys_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, lf_stop = 0;
  logic wake_pin = 0, wake_tick = 0, wake_comp = 0, wake_other = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata_q;
  logic crystal_16m_ok, rc_16m_ok, low_freq_clock, low_freq_ok;
  logic crystal_16m_en_q, rc_16m_en_q, core_src_xtal_q, core_bypass_q;
  logic core_clk_en_q, core_run_q, synth_lf_en_q, timers_on_q;
  logic system_reset_q, crystal_ready_irq_q;
  logic [2:0] low_freq_sel_q, sleep_mode_q;
  int n_fail = 0, total_checks = 0, n_rst = 0, n_irq = 0;
  cpmc_clock_power uut (
    .sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .crystal_16m_ok(crystal_16m_ok),
    .rc_16m_ok(rc_16m_ok), .low_freq_clock(low_freq_clock),
    .low_freq_ok(low_freq_ok), .wake_pin(wake_pin),
    .wake_tick(wake_tick), .wake_comp(wake_comp),
    .wake_other(wake_other), .crystal_16m_en_q(crystal_16m_en_q),
    .rc_16m_en_q(rc_16m_en_q), .core_src_xtal_q(core_src_xtal_q),
    .core_bypass_q(core_bypass_q), .core_clk_en_q(core_clk_en_q),
    .core_run_q(core_run_q), .low_freq_sel_q(low_freq_sel_q),
    .synth_lf_en_q(synth_lf_en_q), .timers_on_q(timers_on_q),
    .sleep_mode_q(sleep_mode_q), .system_reset_q(system_reset_q),
    .crystal_ready_irq_q(crystal_ready_irq_q)
  );
  cpmc_osc_model u_osc (
    .sys_clk(sys_clk), .crystal_16m_en_q(crystal_16m_en_q),
    .rc_16m_en_q(rc_16m_en_q), .lf_stop(lf_stop),
    .crystal_16m_ok(crystal_16m_ok), .rc_16m_ok(rc_16m_ok),
    .low_freq_clock(low_freq_clock), .low_freq_ok(low_freq_ok)
  );
  initial forever #2.5 sys_clk = ~sys_clk;
  // running totals of restart and crystal ready pulses
  always @(posedge sys_clk) begin
    n_rst += system_reset_q;
    n_irq += crystal_ready_irq_q;
  end
  task automatic chk(input logic [7:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  // read, mask and compare the answer in the slot after the strobe
  task automatic rd(input logic [7:0] a, m, e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata_q & m, e);
  endtask
  task automatic wait_run;
    for (int k = 0; k < 400 && core_run_q !== 1'b1; k++) begin
      @(posedge sys_clk);
      #1;
    end
    chk(8'(core_run_q), 8'h01);
  endtask
  // reset values, unmapped place, reserved bits, low source codes
  task automatic t_regs;
    logic [2:0] s;
    rd(ac, 8'hff, 8'h00);
    rd(ap, 8'hff, 8'h00);
    rd(al, 8'h77, 8'h42);
    rd(8'hae, 8'hff, 8'h00);
    wr(al, 8'hff);
    rd(al, 8'h37, 8'h07);
    for (int c = 0; c < 6; c++) begin
      s = c == 5 ? 3'h7 : 3'(c);
      wr(al, {5'h00, s});
      @(posedge sys_clk);
      #1 chk(8'(low_freq_sel_q), 8'(s));
    end
    wr(al, 8'h02);
  endtask
  // core clock pulses in a 128-cycle window for every divider code
  task automatic t_div;
    int n;
    for (int c = 0; c < 8; c++) begin
      wr(ac, 8'(c));
      repeat (8) @(posedge sys_clk);
      n = 0;
      repeat (128) begin
        @(posedge sys_clk);
        #1 n += core_clk_en_q;
      end
      chk(8'(n), 8'(128 >> c));
    end
  endtask
  // enter mode m, wake by w, check restart, irq, cause flags, prev mode
  task automatic t_sleep(input logic [2:0] m, w, input int xr, xi, hold);
    int r0, i0;
    r0 = n_rst;
    i0 = n_irq;
    wr(ap, {5'h00, m});
    repeat (3) @(posedge sys_clk);
    #1 chk(8'(sleep_mode_q), 8'(m));
    chk(8'(core_run_q), 8'h00);
    // low source is active here, so register retention keeps timers
    chk(8'(timers_on_q), 8'(m == 3'h3 || m == 3'h4));
    if (m != 3'h4) chk(8'(synth_lf_en_q), 8'(m == 3'h7));
    lf_stop <= hold[0];
    @(posedge sys_clk);
    {wake_pin, wake_tick, wake_comp} <= w;
    @(posedge sys_clk);
    {wake_pin, wake_tick, wake_comp} <= 3'h0;
    if (hold) begin
      repeat (30) @(posedge sys_clk);
      #1 chk(8'(core_run_q), 8'h00);
      rd(al, 8'hc0, {low_freq_clock, 7'h00});
      lf_stop <= 1'b0;
    end
    wait_run;
    rd(ap, 8'hff, {w, 2'b00, m});
    rd(ap, 8'hff, {5'h00, m});
    wr(ap, 8'h00);
    // let a restarted crystal come up and raise its ready pulse
    repeat (20) @(posedge sys_clk);
    chk(8'(n_rst - r0), 8'(xr));
    chk(8'(n_irq - i0), 8'(xi));
  endtask
  // new oscillator code waits for a retention pass before it acts
  task automatic t_osc(input logic [7:0] v, input logic [1:0] pre,
                       input logic [2:0] e, input int xi);
    wr(ac, v);
    chk(8'({crystal_16m_en_q, rc_16m_en_q}), 8'(pre));
    t_sleep(3'h4, 3'b010, 0, xi, 0);
    chk(8'({crystal_16m_en_q, rc_16m_en_q, core_src_xtal_q}), 8'(e));
    rd(al, 8'h08, {4'h0, e[0], 3'h0});
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    final_report;
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    wait_run;
    repeat (20) @(posedge sys_clk);
    chk(8'(core_src_xtal_q), 8'h01);
    t_regs;
    t_div;
    wr(ac, 8'h08);
    t_sleep(3'h1, 3'b100, 1, 1, 0);
    t_sleep(3'h2, 3'b010, 1, 1, 0);
    t_sleep(3'h3, 3'b001, 1, 1, 0);
    t_sleep(3'h4, 3'b010, 0, 1, 1);
    t_sleep(3'h7, 3'b100, 0, 0, 0);
    wr(ac, 8'h88);
    t_sleep(3'h4, 3'b001, 0, 0, 0);
    t_osc(8'h10, 2'b11, 3'b010, 0);
    t_osc(8'h20, 2'b01, 3'b101, 0);
    t_osc(8'h08, 2'b10, 3'b111, 1);
    wr(ac, 8'h48);
    @(posedge sys_clk);
    #1 chk(8'(core_bypass_q), 8'h01);
    wr(ac, 8'h08);
    @(posedge sys_clk);
    #1 chk(8'(core_bypass_q), 8'h00);
    final_report;
  end
endmodule // clock_and_power_mode_control_tb
`default_nettype wire
